// >>> rtl/stpwm_top.sv
// Six-channel 16-bit modulo timer, PWM part, with AXI4-Lite registers.
// Assumes one clock; the pin clock and channel pins are outside it.
// Function
// - Unbuffered compare uses current compare value directly
// - Compare event ends pulse, wrap ends period
// - Link bit joins even and odd channel
// - Active pair member switches at wrap
// - Odd control unused, odd pin released
// - Action 1:0 clears, 1:1 sets output
// - Overflow toggle flips output at wrap
// - Link bit wins over single mode bit
// - No overflow toggle with clear action gives constant 0% output
// - Full duty plus toggle gives 100% output
// - Wrap flag set at limit, enabled request
// - Compare sets channel flag, enabled request
// - Wait mode keeps counting, blocks register access
// - Counter restarts from zero after limit
// - Divider select picks bus division or pin
// - Clear bit resets counter and prescaler
// - Flag clears by read then write zero
`timescale 1ns/10ps
module stpwm_top
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic waitMode,
  input wire logic extTimerClock,
  output logic [stpwm_pkg::NUM_CH-1:0] chanPinOut,
  output logic [stpwm_pkg::NUM_CH-1:0] chanPinOe,
  output logic wrapIrqReq,
  output logic [stpwm_pkg::NUM_CH-1:0] chanIrqReq,
  output logic irqRequest,
  input wire logic [stpwm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [stpwm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [stpwm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [stpwm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import stpwm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge for the low 16 bits of a word
  function automatic logic [CNT_W-1:0] mergeLanes(input logic [CNT_W-1:0] old,
    input logic [DATA_W-1:0] d, input logic [3:0] s);
    logic [CNT_W-1:0] r;
    r = old;
    if (s[0])
      r[7:0] = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    mergeLanes = r;
  endfunction

  // Channel window hit
  function automatic logic isChan(input logic [ADDR_W-1:0] a);
    isChan = (a >= OFF_CH_BASE) && (a < OFF_CH_END) && (a[1:0] == 2'h0);
  endfunction

  // Channel number from an address in the window
  function automatic int chIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - OFF_CH_BASE;
    chIndex = int'(rel[CH_IDX_LSB +: 3]);
  endfunction

  // Output level after wrap and compare in one counter tick
  function automatic logic nextLevel(input logic lvl, input logic wrap,
    input logic cmp, input stpwm_chan_cfg_t cfg);
    logic v;
    v = lvl;
    if (wrap && cfg.tov)
      v = ~v;
    if (cmp)
    begin
      case (cfg.act)
        ACT_CLEAR: v = 1'b0;
        ACT_SET: v = 1'b1;
        ACT_TOGGLE: v = ~v;
        default: v = v;
      endcase
    end
    if (cfg.tov && cfg.fullDuty)
      v = 1'b1;
    nextLevel = v;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic wrapFlag_reg; // Period-wrap flag
  logic wrapArm_reg; // Flag seen set by a status read
  logic wrapIrqEn_reg; // Period-wrap interrupt enable
  logic halt_reg; // Counter halt
  logic [DIV_W-1:0] div_reg; // Clock divider select
  logic [CNT_W-1:0] count_reg; // Modulo counter
  logic [CNT_W-1:0] limit_reg; // Period limit
  stpwm_chan_cfg_t chCfg_reg [NUM_CH]; // Channel configuration
  logic [NUM_CH-1:0] chFlag_reg; // Channel event flags
  logic [NUM_CH-1:0] chArm_reg; // Channel flags seen set by a read
  logic [CNT_W-1:0] cmp_reg [NUM_CH]; // Compare values
  logic [NUM_CH-1:0] pin_reg; // Channel output levels
  logic [NUM_CH-1:0] pinOe_reg; // Channel output enables
  logic [NUM_PAIR-1:0] lastOdd_reg; // Odd member written last
  logic [NUM_PAIR-1:0] activeOdd_reg; // Odd member in control

  // Bus holding registers
  logic awHeld_reg; // Write address captured
  logic [ADDR_W-1:0] awAddr_reg; // Captured write address
  logic wHeld_reg; // Write data captured
  logic [DATA_W-1:0] wData_reg; // Captured write data
  logic [3:0] wStrb_reg; // Captured strobes
  logic bvalid_reg; // Write response pending
  logic [1:0] bresp_reg; // Write response code
  logic rvalid_reg; // Read data pending
  logic [1:0] rresp_reg; // Read response code
  logic [DATA_W-1:0] rdata_reg; // Read data

  // Decoded strobes and events
  logic doWrite; // Write performed this cycle
  logic wrOk; // Write reaches a register
  logic wrStatus; // Status/control written
  logic wrLimit; // Period limit written
  logic [NUM_CH-1:0] wrCtl; // Channel status/control written
  logic [NUM_CH-1:0] wrCmp; // Channel compare written
  logic clearReq; // Counter clear request
  logic doRead; // Read taken this cycle
  logic rdOk; // Read reaches a register
  logic rdStatus; // Status register read
  logic [NUM_CH-1:0] rdCtl; // Channel status/control read
  logic [DATA_W-1:0] rdValue; // Read mux result
  logic tick; // Counter clock enable
  logic wrapEv; // Counter at limit on a tick
  logic [NUM_CH-1:0] cmpEv; // Compare matched on a tick
  logic [NUM_CH-1:0] slave; // Odd member of a linked pair
  logic [NUM_CH-1:0] outMode; // Channel in compare or PWM use
  logic [CNT_W-1:0] statusWord; // Merged status write value
  logic [CNT_W-1:0] ctlWord; // Merged channel write value

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign awready = !awHeld_reg;
  assign wready = !wHeld_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // Address and data held separately, either may come first
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end
    else
    begin
      if (awvalid && !awHeld_reg)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      else if (doWrite)
        awHeld_reg <= 1'b0;
      if (wvalid && !wHeld_reg)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      else if (doWrite)
        wHeld_reg <= 1'b0;
    end
  end

  // Write decode; in wait mode registers are closed to the CPU
  always_comb
  begin
    doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
    wrOk = doWrite && !waitMode;
    wrStatus = wrOk && (awAddr_reg == OFF_STATUS);
    wrLimit = wrOk && (awAddr_reg == OFF_LIMIT);
    wrCtl = '0;
    wrCmp = '0;
    if (wrOk && isChan(awAddr_reg))
    begin
      if (awAddr_reg[CH_SUB_BIT])
        wrCmp[chIndex(awAddr_reg)] = 1'b1;
      else
        wrCtl[chIndex(awAddr_reg)] = 1'b1;
    end
    statusWord = mergeLanes(CNT_W'(rdStatusByte()), wData_reg, wStrb_reg);
    ctlWord = mergeLanes('0, wData_reg, wStrb_reg);
    clearReq = wrStatus && wStrb_reg[0] && wData_reg[ST_CLEAR];
  end

  // Status byte as software sees it; clear bit always reads zero
  function automatic logic [7:0] rdStatusByte();
    rdStatusByte = {wrapFlag_reg, wrapIrqEn_reg, halt_reg, 2'b00, div_reg};
  endfunction

  // Write response one cycle after both halves are held
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wrStatus || wrLimit || (|wrCtl) || (|wrCmp)) ? RESP_OKAY
        : RESP_SLVERR;
    end
    else if (bready)
      bvalid_reg <= 1'b0;
  end

  // Read decode and data mux
  always_comb
  begin
    doRead = arvalid && !rvalid_reg;
    rdOk = doRead && !waitMode;
    rdStatus = rdOk && (araddr == OFF_STATUS);
    rdCtl = '0;
    rdValue = '0;
    if (araddr == OFF_STATUS)
      rdValue = DATA_W'(rdStatusByte());
    else if (araddr == OFF_COUNT)
      rdValue = DATA_W'(count_reg);
    else if (araddr == OFF_LIMIT)
      rdValue = DATA_W'(limit_reg);
    else if (isChan(araddr))
    begin
      if (araddr[CH_SUB_BIT])
        rdValue = DATA_W'(cmp_reg[chIndex(araddr)]);
      else
      begin
        rdValue = DATA_W'({chFlag_reg[chIndex(araddr)], chCfg_reg[chIndex(araddr)]});
        rdCtl[chIndex(araddr)] = rdOk;
      end
    end
  end

  // Read answer the cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end
    else if (doRead)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= (rdOk && ((araddr <= OFF_LIMIT && araddr[1:0] == 2'h0)
        || isChan(araddr))) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rdOk ? rdValue : '0;
    end
    else if (rready)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  stpwm_prescaler u_prescaler
  (
    .clk(clk),
    .rstn(rstn),
    .clearReq(clearReq),
    .halt(halt_reg),
    .divSel(div_reg),
    .extClk(extTimerClock),
    .tick(tick)
  );

  assign wrapEv = tick && (count_reg == limit_reg);

  // Counts ticks; keeps running in wait mode
  always_ff @(posedge clk)
  begin
    if (!rstn)
      count_reg <= CNT_RST;
    else if (clearReq)
      count_reg <= CNT_RST;
    else if (wrapEv)
      count_reg <= CNT_RST;
    else if (tick)
      count_reg <= count_reg + 16'h0001;
  end

  // Timer control fields
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wrapIrqEn_reg <= 1'b0;
      halt_reg <= 1'b1;
      div_reg <= DIV_RST;
      limit_reg <= LIMIT_RST;
    end
    else
    begin
      if (wrStatus)
      begin
        wrapIrqEn_reg <= statusWord[ST_IRQEN];
        halt_reg <= statusWord[ST_HALT];
        div_reg <= statusWord[DIV_W-1:0];
      end
      if (wrLimit)
        limit_reg <= mergeLanes(limit_reg, wData_reg, wStrb_reg);
    end
  end

  // Wrap flag: a new wrap beats a pending clear and disarms it
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wrapFlag_reg <= 1'b0;
      wrapArm_reg <= 1'b0;
    end
    else if (wrapEv)
    begin
      wrapFlag_reg <= 1'b1;
      wrapArm_reg <= 1'b0;
    end
    else if (wrStatus && wStrb_reg[0] && !wData_reg[ST_FLAG] && wrapArm_reg)
    begin
      wrapFlag_reg <= 1'b0;
      wrapArm_reg <= 1'b0;
    end
    else if (rdStatus && wrapFlag_reg)
      wrapArm_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Compare selection; the active pair member feeds the even channel
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      slave[c] = (c % 2 == 1) && chCfg_reg[c - (c % 2)].link;
      outMode[c] = chCfg_reg[c].link || chCfg_reg[c].single
        || (chCfg_reg[c].act != 2'h0);
      if ((c % 2 == 0) && chCfg_reg[c].link && activeOdd_reg[c / 2])
        cmpEv[c] = tick && (count_reg == cmp_reg[c + 1 - (c % 2)]);
      else
        cmpEv[c] = tick && (count_reg == cmp_reg[c]);
      cmpEv[c] = cmpEv[c] && outMode[c] && !slave[c];
    end
  end

  // Configuration and compare values; compares kept through halt
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!rstn)
      begin
        chCfg_reg[c] <= '0;
        cmp_reg[c] <= '0;
      end
      else
      begin
        if (wrCtl[c])
          chCfg_reg[c] <= stpwm_chan_cfg_t'(ctlWord[CFG_W-1:0]);
        if (wrCmp[c])
          cmp_reg[c] <= mergeLanes(cmp_reg[c], wData_reg, wStrb_reg);
      end
    end
  end

  // Channel flags, same read-then-write-zero clearing as the wrap flag
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!rstn)
      begin
        chFlag_reg[c] <= 1'b0;
        chArm_reg[c] <= 1'b0;
      end
      else if (cmpEv[c])
      begin
        chFlag_reg[c] <= 1'b1;
        chArm_reg[c] <= 1'b0;
      end
      else if (wrCtl[c] && wStrb_reg[0] && !wData_reg[CS_FLAG] && chArm_reg[c])
      begin
        chFlag_reg[c] <= 1'b0;
        chArm_reg[c] <= 1'b0;
      end
      else if (rdCtl[c] && chFlag_reg[c])
        chArm_reg[c] <= 1'b1;
    end
  end

  // Pair member tracking; a write picks the member for the next period
  always_ff @(posedge clk)
  begin
    for (int p = 0; p < NUM_PAIR; p++)
    begin
      if (!rstn || !chCfg_reg[2 * p].link)
      begin
        lastOdd_reg[p] <= 1'b0;
        activeOdd_reg[p] <= 1'b0;
      end
      else
      begin
        if (wrCmp[2 * p + 1])
          lastOdd_reg[p] <= 1'b1;
        else if (wrCmp[2 * p])
          lastOdd_reg[p] <= 1'b0;
        if (wrapEv)
          activeOdd_reg[p] <= lastOdd_reg[p];
      end
    end
  end

  // Output levels change only on wrap or compare, so no glitches
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!rstn)
      begin
        pin_reg[c] <= 1'b0;
        pinOe_reg[c] <= 1'b0;
      end
      else
      begin
        pinOe_reg[c] <= outMode[c] && !slave[c];
        if (!slave[c] && (wrapEv || cmpEv[c]))
          pin_reg[c] <= nextLevel(pin_reg[c], wrapEv, cmpEv[c], chCfg_reg[c]);
      end
    end
  end
  // Without overflow toggle, a clear or set compare only re-forces the held level
  // Compare events end the pulse and wrap events end the period

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign chanPinOut = pin_reg;
  assign chanPinOe = pinOe_reg;
  assign wrapIrqReq = wrapFlag_reg && wrapIrqEn_reg;

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
      chanIrqReq[c] = chFlag_reg[c] && chCfg_reg[c].irqEn;
  end

  // Usable as a wake request while the bus is closed
  assign irqRequest = wrapIrqReq || (|chanIrqReq);

endmodule

// >>> include/stpwm_pkg.sv
// Shared constants and types for the six-channel PWM timer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package stpwm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6; // Channel count
  localparam int NUM_PAIR = 3; // Linkable even/odd pairs
  localparam int ADDR_W = 8; // Register byte address width
  localparam int DATA_W = 32; // Bus data width
  localparam int CNT_W = 16; // Counter, limit and compare width
  localparam int DIV_W = 3; // Clock divider select width
  localparam int PRE_W = 6; // Prescaler counter width

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00; // Timer status and control
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04; // Counter value, read only
  localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h08; // Period limit
  localparam logic [ADDR_W-1:0] OFF_CH_BASE = 8'h10; // Channel 0 status and control
  localparam logic [ADDR_W-1:0] OFF_CH_END = 8'h40; // First address past channels
  localparam int CH_IDX_LSB = 3; // Channel index field of offset
  localparam int CH_SUB_BIT = 2; // 0: status/control, 1: compare

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_FLAG = 7; // Period-wrap flag
  localparam int ST_IRQEN = 6; // Period-wrap interrupt enable
  localparam int ST_HALT = 5; // Counter halt
  localparam int ST_CLEAR = 4; // Counter clear, write only
  localparam int CS_FLAG = 7; // Channel event flag

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] LIMIT_RST = 16'hffff; // Limit after reset
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000; // Counter after reset
  localparam logic [DIV_W-1:0] DIV_EXT = 3'h7; // External timer clock
  localparam logic [DIV_W-1:0] DIV_RST = 3'h0; // Bus clock undivided
  localparam logic [1:0] ACT_TOGGLE = 2'h1; // Toggle on compare
  localparam logic [1:0] ACT_CLEAR = 2'h2; // Clear on compare
  localparam logic [1:0] ACT_SET = 2'h3; // Set on compare
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error

  // Channel configuration, bits 6:0 of a channel status/control word
  typedef struct packed {
    logic irqEn; // Channel event interrupt enable
    logic link; // Pair link bit (even channels)
    logic single; // Single mode bit
    logic [1:0] act; // Compare action hi:lo
    logic tov; // Overflow toggle bit
    logic fullDuty; // Full duty bit
  } stpwm_chan_cfg_t;

  localparam int CFG_W = $bits(stpwm_chan_cfg_t); // Config width

endpackage

// >>> rtl/stpwm_prescaler.sv
// Counter clock source: bus clock divider or synchronised pin clock.
// Assumes clearReq and halt come from logic on clk.
`timescale 1ns/10ps
module stpwm_prescaler
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clearReq,
  input wire logic halt,
  input wire logic [stpwm_pkg::DIV_W-1:0] divSel,
  input wire logic extClk,
  output logic tick
);
  import stpwm_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic extMeta_reg; // First stage, read only by next stage
  logic extSync_reg; // Second stage
  logic extPrev_reg; // Edge history
  logic [PRE_W-1:0] pre_reg; // Free divider count
  logic [PRE_W-1:0] mask; // Low bits that must all be ones
  logic extRise; // Rising edge of pin clock

  // Two flops before any logic looks at the pin
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
      extPrev_reg <= 1'b0;
    end
    else
    begin
      extMeta_reg <= extClk;
      extSync_reg <= extMeta_reg;
      extPrev_reg <= extSync_reg;
    end
  end

  assign extRise = extSync_reg & ~extPrev_reg;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Held at zero while halted so a restart begins a full division
  always_ff @(posedge clk)
  begin
    if (!rstn || clearReq || halt)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + 6'h01;
  end

  // Division 2^n: tick when the n low bits are all ones
  always_comb
  begin
    mask = PRE_W'((7'h01 << divSel) - 7'h01);
    if (halt || clearReq)
      tick = 1'b0;
    else if (divSel == DIV_EXT)
      tick = extRise;
    else
      tick = ((pre_reg & mask) == mask);
  end

endmodule

// >>> test/stpwm_properties.sv
// Checker for the PWM timer top: bus answers, wait mode, interrupt lines.
// Assumes it is bound to stpwm_top and sees only that module's ports.
`timescale 1ns/10ps
module stpwm_props
  import stpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic waitMode,
  input wire logic [stpwm_pkg::NUM_CH-1:0] chanPinOut,
  input wire logic wrapIrqReq,
  input wire logic [stpwm_pkg::NUM_CH-1:0] chanIrqReq,
  input wire logic irqRequest,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [stpwm_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  // ----------------------------------------
  // Properties, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Summary request must follow every enabled source
  property p_irqOr;
    irqRequest == (wrapIrqReq || (|chanIrqReq));
  endproperty
  a_irqOr: assert property (p_irqOr) else $error("irq summary wrong");
  property p_waitRd;
    arvalid && arready && waitMode |=> rresp == RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_waitRd: assert property (p_waitRd) else $error("wait read not refused");
  property p_rdAns;
    arvalid && arready |=> rvalid;
  endproperty
  a_rdAns: assert property (p_rdAns) else $error("read answer late");
  // Answers hold until taken, else data is lost
  property p_rdHold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read answer dropped");
  property p_bHold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  property p_wrAns;
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid;
  endproperty
  a_wrAns: assert property (p_wrAns) else $error("write answer late");
  property p_arBlock;
    rvalid |-> !arready;
  endproperty
  a_arBlock: assert property (p_arBlock) else $error("second read taken");
  // Pins and requests start quiet after reset
  property p_rstQuiet;
    $rose(rstn) |-> chanPinOut == 6'h00 && !irqRequest && !bvalid && !rvalid;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("not quiet after reset");
  c_wait: cover property (waitMode && rvalid);
  c_wrapIrq: cover property (wrapIrqReq);
  c_chanIrq: cover property (|chanIrqReq);
endmodule

bind stpwm_top stpwm_props u_props (.clk(clk), .rstn(rstn), .waitMode(waitMode),
  .chanPinOut(chanPinOut), .wrapIrqReq(wrapIrqReq), .chanIrqReq(chanIrqReq),
  .irqRequest(irqRequest), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

// >>> test/tb.sv
// Self-checking bench for the PWM timer: registers, PWM shapes, wait mode.
// Assumes stpwm_top with its checker bound; clock 10 MHz.
`timescale 1ns/10ps
`define CHK(a,b) begin checkCount++; if ((a) !== (b)) begin badCount++; $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
  import stpwm_pkg::*;
  logic clk = 0, rstn = 0, waitMode = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, wIrq, irq;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, lastData;
  logic [1:0] bresp, rresp, lastResp;
  logic [NUM_CH-1:0] pin, oe, cIrq;
  logic ext = 0;
  int badCount = 0, checkCount = 0, hi;
  always #50 clk = ~clk;
  // Pin clock at half the bus clock, its fastest legal rate
  always @(posedge clk) ext <= ~ext;
  stpwm_top dut (.clk(clk), .rstn(rstn), .waitMode(waitMode), .extTimerClock(ext),
    .chanPinOut(pin), .chanPinOe(oe), .wrapIrqReq(wIrq), .chanIrqReq(cIrq),
    .irqRequest(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Bus write; readies and answer sampled at the rising edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (awready && !ad)
        awvalid <= 1'b0;
      if (wready && !wd)
        wvalid <= 1'b0;
      ad = ad | awready;
      wd = wd | wready;
    end
    ad = 0;
    while (!ad)
    begin
      @(posedge clk);
      ad = bvalid;
      lastResp = bresp;
    end
    bready <= 1'b0;
  endtask
  // Bus read; answer captured at the edge where it is taken
  task automatic rd(input logic [7:0] a);
    logic t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t)
    begin
      @(posedge clk);
      t = arready;
    end
    arvalid <= 1'b0;
    t = 0;
    while (!t)
    begin
      @(posedge clk);
      t = rvalid;
      lastData = rdata;
      lastResp = rresp;
    end
    rready <= 1'b0;
  endtask
  // High cycles of one pin over a window, after settling
  task automatic hiCount(input int ch, input int n);
    repeat (25) @(posedge clk);
    hi = 0;
    repeat (n)
    begin
      @(negedge clk);
      hi += pin[ch];
    end
  endtask
  task automatic tReset();
    rd(8'h00);
    `CHK(lastData, 32'h20)
    rd(8'h08);
    `CHK(lastData, 32'hffff)
    rd(8'hfc);
    `CHK(lastResp, RESP_SLVERR)
  endtask
  // Unbuffered PWM, limit 9, compare 4, clear on compare
  task automatic tPwm();
    wr(8'h00, 32'h30);
    rd(8'h00);
    `CHK(lastData, 32'h20)
    wr(8'h08, 32'h9);
    wr(8'h14, 32'h4);
    wr(8'h10, 32'h5a);
    wr(8'h00, 32'h0);
    hiCount(0, 10);
    `CHK(hi, 5)
    rd(8'h00);
    `CHK(lastData, 32'h80)
    `CHK(wIrq, 1'b0)
    rd(8'h04);
    `CHK(lastData <= 32'h9, 1'b1)
    rd(8'h10);
    `CHK(lastData, 32'hda)
    `CHK(cIrq[0], 1'b1)
    // Shorter width written just after the compare, longer just after a wrap
    @(negedge pin[0]);
    wr(8'h14, 32'h2);
    hiCount(0, 10);
    `CHK(hi, 3)
    @(posedge pin[0]);
    wr(8'h14, 32'h4);
    hiCount(0, 10);
    `CHK(hi, 5)
  endtask
  // Flag survives a write of 1, clears on read then write 0
  task automatic tClear();
    wr(8'h00, 32'ha0);
    rd(8'h00);
    `CHK(lastData, 32'ha0)
    wr(8'h00, 32'h20);
    rd(8'h00);
    `CHK(lastData, 32'h20)
  endtask
  // Wait mode: refused access, counting and requests go on
  task automatic tWait();
    wr(8'h00, 32'h40);
    repeat (15) @(posedge clk);
    `CHK(wIrq, 1'b1)
    @(posedge clk);
    waitMode <= 1'b1;
    rd(8'h00);
    `CHK({lastResp, lastData}, {RESP_SLVERR, 32'h0})
    wr(8'h08, 32'h3);
    `CHK(lastResp, RESP_SLVERR)
    `CHK(irq, 1'b1)
    waitMode <= 1'b0;
    rd(8'h08);
    `CHK(lastData, 32'h9)
  endtask
  task automatic tDuty();
    wr(8'h10, 32'h18);
    hiCount(0, 20);
    `CHK(hi, 0)
    wr(8'h10, 32'h1b);
    hiCount(0, 20);
    `CHK(hi, 20)
  endtask
  // Linked pair 2/3: odd released, odd compare takes over at a wrap
  task automatic tLink();
    wr(8'h24, 32'h3);
    wr(8'h20, 32'h3a);
    hiCount(2, 10);
    `CHK(hi, 4)
    `CHK(oe[3:2], 2'h1)
    wr(8'h2c, 32'h7);
    hiCount(2, 10);
    `CHK(hi, 8)
  endtask
  // Bus clock halved, then pin clock: period doubles to 20 cycles
  task automatic tDiv();
    wr(8'h00, 32'h1);
    hiCount(2, 20);
    `CHK(hi, 16)
    wr(8'h00, 32'h7);
    hiCount(2, 20);
    `CHK(hi, 16)
  endtask
  task automatic tallyAndFinish();
    if (badCount == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    tReset();
    tPwm();
    tClear();
    tWait();
    tDuty();
    tLink();
    tDiv();
    tallyAndFinish();
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #500000;
    badCount++;
    tallyAndFinish();
  end
endmodule
